/* File: charger_status_registers.sv */
// Function
// - Status zero bits 7:5 show input source: none, USB, adapter, boost.
// - Status zero bits 4:3 show charge phase: idle, precharge, fast, done.
// - Status zero bit 0 high while system rail held at floor level.
// - Status zero bit 1 high while die thermal regulation is active.
// - Watchdog fault reads 1 after reset or expiry, 0 under host control.
// - Fault bit 6 set on boost overload or boost battery too low.
// - Fault bits 5:4 give charge error; 11 means safety timer expired.
// - Buck mode thermistor codes: normal, warm, cool, cold, hot.
// - Boost mode thermistor codes limited to normal, cold and hot.
// - Status two bit 7 high when input passes poor-source check.
// - Status two bit 4 high when remote sense pin open or shorted.
// - Status two bit 3 high while top-off timer is counting.
// - Voltage loop entry pulses interrupt unless mask bit 1 set; resets 0.
// - Current loop entry pulses interrupt unless mask bit 0 set; resets 0.
// - Writing register reset bit restores both interrupt masks to 0, then bit clears itself.
module charger_status_registers
#(
   parameter logic [3:0] PART_CODE = 4'hA  // Arbitrary value
)
(
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic [2:0] input_source_type,
   input  wire logic [1:0] charge_phase,
   input  wire logic       power_good_flag,
   input  wire logic       die_heat_regulating,
   input  wire logic       system_floor_regulating,
   input  wire logic       boost_overload,
   input  wire logic       boost_battery_low,
   input  wire logic       input_fault,
   input  wire logic       thermal_shutdown,
   input  wire logic       safety_timer_expired,
   input  wire logic       battery_overvoltage_flag,
   input  wire logic       thermistor_hot,
   input  wire logic       thermistor_warm,
   input  wire logic       thermistor_cool,
   input  wire logic       thermistor_cold,
   input  wire logic       input_qualified,
   input  wire logic       input_voltage_loop_active,
   input  wire logic       input_current_loop_active,
   input  wire logic       remote_sense_fallback,
   input  wire logic       topoff_counting,
   input  wire logic       input_overvoltage_flag,
   input  wire logic       watchdog_expired,
   input  wire logic       host_control_taken,
   output logic            int_pulse,
   output logic            reg_reset_pulse
);

   typedef struct packed {
      logic [7:0] rdata;
      logic       wd_fault;
      logic       boost_fault;
      logic       bat_ov;
      logic [1:0] chg_err;
      logic       vblock;
      logic       iblock;
      logic       rst_pend;
   } regs_state_t;

   localparam regs_state_t STATE_RESET = '{
      rdata       : charger_status_pkg::UNMAPPED_READ,
      wd_fault    : charger_status_pkg::WATCHDOG_RESET,
      boost_fault : 1'b0,
      bat_ov      : 1'b0,
      chg_err     : charger_status_pkg::CHG_ERR_NONE,
      vblock      : charger_status_pkg::IRQ_BLOCK_RESET,
      iblock      : charger_status_pkg::IRQ_BLOCK_RESET,
      rst_pend    : 1'b0
   };

   regs_state_t s;
   regs_state_t next_s;

   logic [23:0] raw;
   logic [23:0] sy;
   logic [2:0]  sy_src;
   logic [1:0]  sy_phase;
   logic        sy_pg;
   logic        sy_heat;
   logic        sy_floor;
   logic        sy_bovl;
   logic        sy_blow;
   logic        sy_infault;
   logic        sy_tshut;
   logic        sy_timer;
   logic        sy_batov;
   logic        sy_hot;
   logic        sy_warm;
   logic        sy_cool;
   logic        sy_cold;
   logic        sy_qual;
   logic        sy_vloop;
   logic        sy_iloop;
   logic        sy_fallback;
   logic        sy_topoff;
   logic        sy_acov;
   logic        boosting;
   logic [2:0]  zone;
   logic [1:0]  live_err;
   logic [7:0]  status_zero;
   logic [7:0]  fault_status;
   logic [7:0]  status_two;
   logic [7:0]  part_info;
   logic        rd_fault;
   logic        vpulse;
   logic        ipulse;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   assign raw = {input_source_type, charge_phase, power_good_flag,
                 die_heat_regulating, system_floor_regulating,
                 boost_overload, boost_battery_low, input_fault,
                 thermal_shutdown, safety_timer_expired,
                 battery_overvoltage_flag, thermistor_hot,
                 thermistor_warm, thermistor_cool, thermistor_cold,
                 input_qualified, input_voltage_loop_active,
                 input_current_loop_active, remote_sense_fallback,
                 topoff_counting, input_overvoltage_flag};

   status_sync #(.W(24)) u_sync
   (
      .clock    (clock),
      .rstn     (rstn),
      .async_in (raw),
      .sync_out (sy)
   );

   assign {sy_src, sy_phase, sy_pg, sy_heat, sy_floor, sy_bovl, sy_blow,
           sy_infault, sy_tshut, sy_timer, sy_batov, sy_hot, sy_warm,
           sy_cool, sy_cold, sy_qual, sy_vloop, sy_iloop, sy_fallback,
           sy_topoff, sy_acov} = sy;

   assign boosting = (sy_src == charger_status_pkg::SOURCE_BOOST);

   // ----------------------------------------------------------------
   // Live codes
   // ----------------------------------------------------------------
   always_comb
   begin
      if (sy_hot)
         zone = charger_status_pkg::ZONE_HOT;
      else if (sy_cold)
         zone = charger_status_pkg::ZONE_COLD;
      else if (sy_warm && !boosting)
         zone = charger_status_pkg::ZONE_WARM;
      else if (sy_cool && !boosting)
         zone = charger_status_pkg::ZONE_COOL;
      else
         zone = charger_status_pkg::ZONE_NORMAL;
      if (sy_timer)
         live_err = charger_status_pkg::CHG_ERR_TIMER;
      else if (sy_tshut)
         live_err = charger_status_pkg::CHG_ERR_THERMAL;
      else if (sy_infault)
         live_err = charger_status_pkg::CHG_ERR_INPUT;
      else
         live_err = charger_status_pkg::CHG_ERR_NONE;
   end

   // ----------------------------------------------------------------
   // Read images
   // ----------------------------------------------------------------
   // live status zero
   assign status_zero = {sy_src, sy_phase, sy_pg, sy_heat, sy_floor};
   assign fault_status = {s.wd_fault, s.boost_fault, s.chg_err, s.bat_ov,
                          zone};
   assign status_two = {sy_qual, sy_vloop, sy_iloop, sy_fallback,
                        sy_topoff, sy_acov, s.vblock, s.iblock};
   assign part_info = {s.rst_pend, PART_CODE,
                       charger_status_pkg::PART_RESERVED};
   assign rd_fault = reg_rd
                   && (reg_addr == charger_status_pkg::FAULT_STATUS_ADDR);

   // ----------------------------------------------------------------
   // Register update
   // ----------------------------------------------------------------
   always_comb
   begin
      next_s          = s;
      next_s.rst_pend = 1'b0;
      if (reg_rd)
      begin
         case (reg_addr)
            charger_status_pkg::STATUS_ZERO_ADDR:  next_s.rdata = status_zero;
            charger_status_pkg::FAULT_STATUS_ADDR: next_s.rdata = fault_status;
            charger_status_pkg::STATUS_TWO_ADDR:   next_s.rdata = status_two;
            charger_status_pkg::PART_INFO_ADDR:    next_s.rdata = part_info;
            default: next_s.rdata = charger_status_pkg::UNMAPPED_READ;
         endcase
      end
      next_s.wd_fault = watchdog_expired | (s.wd_fault & ~host_control_taken);
      // faults latch until read, set wins
      next_s.boost_fault = sy_bovl | sy_blow | (s.boost_fault & ~rd_fault);
      next_s.bat_ov      = sy_batov | (s.bat_ov & ~rd_fault);
      if (live_err != charger_status_pkg::CHG_ERR_NONE)
         next_s.chg_err = live_err;
      else if (rd_fault)
         next_s.chg_err = charger_status_pkg::CHG_ERR_NONE;
      if (reg_wr && (reg_addr == charger_status_pkg::STATUS_TWO_ADDR))
      begin
         next_s.vblock = reg_wdata[charger_status_pkg::VBLOCK_BIT];
         next_s.iblock = reg_wdata[charger_status_pkg::IBLOCK_BIT];
      end
      if (reg_wr && (reg_addr == charger_status_pkg::PART_INFO_ADDR)
          && reg_wdata[charger_status_pkg::REG_RESET_BIT])
      begin
         next_s.vblock   = charger_status_pkg::IRQ_BLOCK_RESET;
         next_s.iblock   = charger_status_pkg::IRQ_BLOCK_RESET;
         next_s.rst_pend = 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
         s <= STATE_RESET;
      else
         s <= next_s;
   end

   // ----------------------------------------------------------------
   // Interrupt pulses
   // ----------------------------------------------------------------
   // voltage loop entry
   irq_edge u_vedge
   (
      .clock (clock),
      .rstn  (rstn),
      .level (sy_vloop),
      .block (s.vblock),
      .pulse (vpulse)
   );

   irq_edge u_iedge
   (
      .clock (clock),
      .rstn  (rstn),
      .level (sy_iloop),
      .block (s.iblock),
      .pulse (ipulse)
   );

   assign int_pulse       = vpulse | ipulse;
   assign reg_rdata       = s.rdata;
   assign reg_reset_pulse = s.rst_pend;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence rd_zero;
      reg_rd && (reg_addr == charger_status_pkg::STATUS_ZERO_ADDR);
   endsequence

   sequence reset_write;
      reg_wr && (reg_addr == charger_status_pkg::PART_INFO_ADDR)
      && reg_wdata[charger_status_pkg::REG_RESET_BIT];
   endsequence

   source_field_a: assert property (rd_zero |=>
      reg_rdata[7:5] == $past(sy_src))
      else $error("source field mismatch");

   phase_field_a: assert property (rd_zero |=>
      reg_rdata[4:3] == $past(sy_phase))
      else $error("charge phase mismatch");

   floor_bit_a: assert property (rd_zero |=>
      reg_rdata[0] == $past(sy_floor))
      else $error("system floor bit mismatch");

   heat_bit_a: assert property (rd_zero |=>
      reg_rdata[1] == $past(sy_heat))
      else $error("die heat bit mismatch");

   watchdog_set_a: assert property (watchdog_expired |=>
      s.wd_fault ##1 (s.wd_fault || $past(host_control_taken)))
      else $error("watchdog fault not set");

   boost_fault_a: assert property ((sy_bovl || sy_blow) |=>
      s.boost_fault)
      else $error("boost fault not latched");

   timer_code_a: assert property (sy_timer |=>
      s.chg_err == charger_status_pkg::CHG_ERR_TIMER)
      else $error("timer expiry code missing");

   boost_zone_a: assert property (boosting |->
      (zone != charger_status_pkg::ZONE_WARM)
      && (zone != charger_status_pkg::ZONE_COOL))
      else $error("warm or cool in boost");

   vloop_irq_a: assert property (($rose(sy_vloop) && !s.vblock) |=>
      int_pulse)
      else $error("voltage loop pulse missing");

   iloop_block_a: assert property (($rose(sy_iloop) && s.iblock
      && !sy_vloop && !$past(sy_vloop)) |=> !int_pulse)
      else $error("blocked current pulse seen");

   reg_reset_a: assert property (reset_write |=>
      reg_reset_pulse && !s.vblock && !s.iblock ##1 !reg_reset_pulse)
      else $error("register reset sequence wrong");

   mask_write_a: assert property ((reg_wr
      && reg_addr == charger_status_pkg::STATUS_TWO_ADDR) |=>
      {s.vblock, s.iblock} == $past(reg_wdata[1:0]))
      else $error("mask write not stored");

endmodule : charger_status_registers

/* File: charger_status_pkg.sv */
package charger_status_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] STATUS_ZERO_ADDR  = 8'h08;
   localparam logic [7:0] FAULT_STATUS_ADDR = 8'h09;
   localparam logic [7:0] STATUS_TWO_ADDR   = 8'h0A;
   localparam logic [7:0] PART_INFO_ADDR    = 8'h0B;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SOURCE_LSB      = 5;
   localparam int PHASE_LSB       = 3;
   localparam int POWER_GOOD_BIT  = 2;
   localparam int DIE_HEAT_BIT    = 1;
   localparam int SYS_FLOOR_BIT   = 0;
   localparam int WATCHDOG_BIT    = 7;
   localparam int BOOST_FAULT_BIT = 6;
   localparam int CHARGE_ERR_LSB  = 4;
   localparam int BAT_OV_BIT      = 3;
   localparam int THERM_LSB       = 0;
   localparam int QUALIFIED_BIT   = 7;
   localparam int VLOOP_BIT       = 6;
   localparam int ILOOP_BIT       = 5;
   localparam int FALLBACK_BIT    = 4;
   localparam int TOPOFF_BIT      = 3;
   localparam int OVERVOLT_BIT    = 2;
   localparam int VBLOCK_BIT      = 1;
   localparam int IBLOCK_BIT      = 0;
   localparam int REG_RESET_BIT   = 7;
   localparam int PART_CODE_LSB   = 3;

   // ----------------------------------------------------------------
   // Codes and reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] SOURCE_BOOST     = 3'h7;
   localparam logic [1:0] CHG_ERR_NONE     = 2'h0;
   localparam logic [1:0] CHG_ERR_INPUT    = 2'h1;
   localparam logic [1:0] CHG_ERR_THERMAL  = 2'h2;
   localparam logic [1:0] CHG_ERR_TIMER    = 2'h3;
   localparam logic [2:0] ZONE_NORMAL      = 3'h0;
   localparam logic [2:0] ZONE_WARM        = 3'h2;
   localparam logic [2:0] ZONE_COOL        = 3'h3;
   localparam logic [2:0] ZONE_COLD        = 3'h5;
   localparam logic [2:0] ZONE_HOT         = 3'h6;
   localparam logic [2:0] PART_RESERVED    = 3'h4;
   localparam logic       WATCHDOG_RESET   = 1'b1;
   localparam logic       IRQ_BLOCK_RESET  = 1'b0;
   localparam logic [7:0] UNMAPPED_READ    = 8'h00;

endpackage : charger_status_pkg

/* File: status_sync.sv */
module status_sync
#(
   parameter int W = 24
)
(
   input  wire logic         clock,
   input  wire logic         rstn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } sync_state_t;

   sync_state_t s;
   sync_state_t next_s;

   if (W < 1)
   begin : g_check
      $error("status_sync width must be at least one");
   end

   // ----------------------------------------------------------------
   // Two flip-flop stage
   // ----------------------------------------------------------------
   always_comb
   begin
      next_s      = s;
      next_s.meta = async_in;
      next_s.q    = s.meta;
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
         s <= '0;
      else
         s <= next_s;
   end

   assign sync_out = s.q;

endmodule : status_sync

/* File: irq_edge.sv */
module irq_edge
(
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic level,
   input  wire logic block,
   output logic      pulse
);

   typedef struct packed {
      logic prev;
      logic pulse;
   } edge_state_t;

   edge_state_t s;
   edge_state_t next_s;

   // ----------------------------------------------------------------
   // Entry detect, gated by block
   // ----------------------------------------------------------------
   always_comb
   begin
      next_s       = s;
      next_s.prev  = level;
      next_s.pulse = level & ~s.prev & ~block;
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
         s <= '0;
      else
         s <= next_s;
   end

   assign pulse = s.pulse;

endmodule : irq_edge

/* File: status_host_model.sv */
module status_host_model
(
   input  wire logic       clock,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       int_pulse
);
   timeunit 1ns;
   timeprecision 1ps;

   int irq_count = 0;

   // ---------------------------------------------------------------
   // Strobes idle, released lines show the inverse of the last value
   // ---------------------------------------------------------------
   initial
   begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 8'h00;
   end

   always @(posedge clock)
      if (int_pulse === 1'b1)
         irq_count++;

   task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      #1;
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = v;
      @(posedge clock);
      #1;
      reg_wr    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~v;
   endtask : write_reg

   task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clock);
      #1;
      reg_rd   = 1'b1;
      reg_addr = a;
      @(posedge clock);
      #1;
      reg_rd   = 1'b0;
      reg_addr = ~a;
      @(posedge clock);
      #1;
      v = reg_rdata;
   endtask : read_reg
endmodule : status_host_model

/* File: tb_charger_status_registers.sv */
`define CHK(what, exp, got) \
   begin \
      check_count++; \
      if ((got) !== (exp)) \
      begin \
         fail_count++; \
         $display("[ERR] %s expected %h seen %h", what, exp, got); \
      end \
   end

module tb_charger_status_registers;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clock, rstn, reg_wr, reg_rd, int_pulse, reg_reset_pulse;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [2:0] input_source_type;
   logic [1:0] charge_phase;
   logic power_good_flag, die_heat_regulating, system_floor_regulating;
   logic boost_overload, boost_battery_low, input_fault, thermal_shutdown;
   logic safety_timer_expired, battery_overvoltage_flag;
   logic thermistor_hot, thermistor_warm, thermistor_cool, thermistor_cold;
   logic input_qualified, input_voltage_loop_active;
   logic input_current_loop_active, remote_sense_fallback;
   logic topoff_counting, input_overvoltage_flag;
   logic watchdog_expired, host_control_taken;
   int   fail_count = 0;
   int   check_count = 0;
   int   rr_count = 0;
   int   base;

   charger_status_registers #(.PART_CODE(4'h9)) dut_u (.*); // Arbitrary

   status_host_model host_u
   (
      .clock     (clock),
      .reg_addr  (reg_addr),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_wdata (reg_wdata),
      .reg_rdata (reg_rdata),
      .int_pulse (int_pulse)
   );

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   always @(posedge clock)
      if (reg_reset_pulse === 1'b1)
         rr_count++;

   task automatic settle;
      repeat (4) @(posedge clock);
      #1;
   endtask : settle

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic test_reset;
      host_u.read_reg(charger_status_pkg::FAULT_STATUS_ADDR, d);
      `CHK("fault byte", 8'h80, d)
      host_u.read_reg(charger_status_pkg::STATUS_TWO_ADDR, d);
      `CHK("masks", 2'b00, d[1:0])
      host_u.read_reg(charger_status_pkg::PART_INFO_ADDR, d);
      `CHK("part info", 8'h4C, d)
      host_u.write_reg(8'h20, 8'hFF);
      host_u.read_reg(8'h20, d);
      `CHK("unmapped", 8'h00, d)
      host_u.write_reg(charger_status_pkg::STATUS_ZERO_ADDR, 8'hFF);
      host_u.read_reg(charger_status_pkg::STATUS_ZERO_ADDR, d);
      `CHK("status zero ro", 8'h00, d)
      $display("test_reset done");
   endtask : test_reset

   task automatic test_status0;
      logic [2:0] src [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
      logic [7:0] e;
      for (int i = 0; i < 4; i++)
      begin
         input_source_type = src[i];
         charge_phase = 2'(i);
         power_good_flag = i[0];
         die_heat_regulating = ~i[0];
         system_floor_regulating = i[1];
         settle();
         host_u.read_reg(charger_status_pkg::STATUS_ZERO_ADDR, d);
         e = {src[i], 2'(i), i[0], ~i[0], i[1]};
         `CHK("status zero", e, d)
      end
      input_source_type = 3'h0;
      $display("test_status0 done");
   endtask : test_status0

   task automatic test_faults;
      logic [3:0] exp [6] = '{4'h8, 4'h8, 4'h2, 4'h4, 4'h6, 4'h1};
      for (int k = 0; k < 6; k++)
      begin
         {boost_overload, boost_battery_low, input_fault, thermal_shutdown,
          safety_timer_expired, battery_overvoltage_flag} = 6'h20 >> k;
         settle();
         {boost_overload, boost_battery_low, input_fault, thermal_shutdown,
          safety_timer_expired, battery_overvoltage_flag} = 6'h00;
         settle();
         host_u.read_reg(charger_status_pkg::FAULT_STATUS_ADDR, d);
         `CHK("fault latched", exp[k], d[6:3])
         host_u.read_reg(charger_status_pkg::FAULT_STATUS_ADDR, d);
         `CHK("fault cleared", 4'h0, d[6:3])
      end
      $display("test_faults done");
   endtask : test_faults

   task automatic test_thermistor;
      logic [2:0] buck [4] = '{3'h6, 3'h2, 3'h3, 3'h5};
      logic [2:0] bst [4] = '{3'h6, 3'h0, 3'h0, 3'h5};
      for (int m = 0; m < 2; m++)
         for (int k = 0; k < 4; k++)
         begin
            input_source_type = m ? 3'h7 : 3'h0;
            {thermistor_hot, thermistor_warm, thermistor_cool,
             thermistor_cold} = 4'h8 >> k;
            settle();
            host_u.read_reg(charger_status_pkg::FAULT_STATUS_ADDR, d);
            `CHK("zone", m ? bst[k] : buck[k], d[2:0])
         end
      {thermistor_hot, thermistor_warm, thermistor_cool,
       thermistor_cold} = 4'h0;
      input_source_type = 3'h0;
      settle();
      host_u.read_reg(charger_status_pkg::FAULT_STATUS_ADDR, d);
      `CHK("zone normal", 3'h0, d[2:0])
      $display("test_thermistor done");
   endtask : test_thermistor

   task automatic test_status2;
      logic [3:0] v;
      for (int k = 0; k < 4; k++)
      begin
         v = 4'h8 >> k;
         {input_qualified, remote_sense_fallback, topoff_counting,
          input_overvoltage_flag} = v;
         settle();
         host_u.read_reg(charger_status_pkg::STATUS_TWO_ADDR, d);
         `CHK("status two", {v[3], 2'b00, v[2:0], 2'b00}, d)
      end
      input_overvoltage_flag = 1'b0;
      input_qualified = 1'b1;
      settle();
      host_u.write_reg(charger_status_pkg::STATUS_TWO_ADDR, 8'hFC);
      host_u.read_reg(charger_status_pkg::STATUS_TWO_ADDR, d);
      `CHK("status two ro", 8'h80, d)
      input_qualified = 1'b0;
      $display("test_status2 done");
   endtask : test_status2

   task automatic test_irq;
      for (int k = 0; k < 2; k++)
         for (int m = 0; m < 2; m++)
         begin
            host_u.write_reg(charger_status_pkg::STATUS_TWO_ADDR,
                             m ? (k ? 8'h01 : 8'h02) : 8'h00);
            base = host_u.irq_count;
            if (k)
               input_current_loop_active = 1'b1;
            else
               input_voltage_loop_active = 1'b1;
            repeat (8) @(posedge clock);
            #1;
            `CHK("irq pulses", m ? 0 : 1, host_u.irq_count - base)
            host_u.read_reg(charger_status_pkg::STATUS_TWO_ADDR, d);
            `CHK("loop bits", k ? 2'b01 : 2'b10, d[6:5])
            input_current_loop_active = 1'b0;
            input_voltage_loop_active = 1'b0;
            settle();
         end
      $display("test_irq done");
   endtask : test_irq

   task automatic test_regreset;
      host_u.write_reg(charger_status_pkg::STATUS_TWO_ADDR, 8'h03);
      host_u.read_reg(charger_status_pkg::STATUS_TWO_ADDR, d);
      `CHK("masks set", 2'b11, d[1:0])
      base = rr_count;
      host_u.write_reg(charger_status_pkg::PART_INFO_ADDR, 8'h80);
      repeat (2) @(posedge clock);
      #1;
      `CHK("reset pulses", 1, rr_count - base)
      host_u.read_reg(charger_status_pkg::STATUS_TWO_ADDR, d);
      `CHK("masks default", 2'b00, d[1:0])
      host_u.read_reg(charger_status_pkg::PART_INFO_ADDR, d);
      `CHK("reset bit", 1'b0, d[7])
      $display("test_regreset done");
   endtask : test_regreset

   task automatic test_watchdog;
      host_control_taken = 1'b1;
      @(posedge clock);
      #1;
      host_control_taken = 1'b0;
      host_u.read_reg(charger_status_pkg::FAULT_STATUS_ADDR, d);
      `CHK("host mode", 1'b0, d[7])
      watchdog_expired = 1'b1;
      @(posedge clock);
      #1;
      watchdog_expired = 1'b0;
      host_u.read_reg(charger_status_pkg::FAULT_STATUS_ADDR, d);
      `CHK("default mode", 1'b1, d[7])
      $display("test_watchdog done");
   endtask : test_watchdog

   initial
   begin
      rstn = 1'b0;
      {input_source_type, charge_phase, power_good_flag, die_heat_regulating,
       system_floor_regulating, boost_overload, boost_battery_low,
       input_fault, thermal_shutdown, safety_timer_expired,
       battery_overvoltage_flag, thermistor_hot, thermistor_warm,
       thermistor_cool, thermistor_cold, input_qualified,
       input_voltage_loop_active, input_current_loop_active,
       remote_sense_fallback, topoff_counting, input_overvoltage_flag,
       watchdog_expired, host_control_taken} = '0;
      repeat (2) @(posedge clock);
      #1;
      rstn = 1'b1;
      settle();
      test_reset();
      test_status0();
      test_faults();
      test_thermistor();
      test_status2();
      test_irq();
      test_regreset();
      test_watchdog();
      tally_and_finish();
   end

   initial
   begin
      #100000;
      fail_count++;
      tally_and_finish();
   end
endmodule : tb_charger_status_registers
